// ===== output_channel_regs.svh
// register offsets, reset values and framing constants of the packet mux
`ifndef OUTPUT_CHANNEL_REGS_SVH
`define OUTPUT_CHANNEL_REGS_SVH

`define OCM_OFS_CTRL 8'h00
`define OCM_OFS_STATUS 8'h04
`define OCM_OFS_PKG_COUNT 8'h08
`define OCM_OFS_SCALAR 8'h0C
`define OCM_OFS_TABLE_INDEX 8'h10
`define OCM_OFS_TABLE_DATA 8'h14
`define OCM_OFS_FORMAT 8'h18

`define OCM_CTRL_ENABLE_BIT 0
`define OCM_CTRL_SHARED_BIT 1
`define OCM_CTRL_RESET 32'h0000_0001
`define OCM_STATUS_BUSY_BIT 16

`define OCM_MAX_CHANNELS 16
`define OCM_MAX_WORD_BITS 1024
`define OCM_STREAM_BITS 256
`define OCM_SWITCH_BITS 128
`define OCM_PAYLOAD_BEATS 64
`define OCM_HEADER_BEATS 2
`define OCM_FIFO_DEPTH 32

`define OCM_RESP_OKAY 2'h0
`define OCM_RESP_SLVERR 2'h2

`endif

// ===== output_channel_pkg.sv
// types shared by the packet mux files
package output_channel_pkg;
    typedef enum logic [0:0] {
        SW_IDLE,
        SW_PACKAGE
    } switch_state_t;
endpackage

// ===== channel_fifo.sv
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module channel_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_check
        $error("channel_fifo: DEPTH must be at least 2, WIDTH at least 1");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] count_q;
    logic room_q;
    logic push;
    logic pop;
    logic [CW-1:0] count_d;

    assign in_ready = room_q;
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && room_q;
    assign pop = out_valid && out_ready;
    assign count_d = count_q + CW'(push) - CW'(pop);

    always_ff @(posedge aclk) begin
        if (ce && push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
            room_q <= 1'b1;
        end else if (ce) begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            count_q <= count_d;
            room_q <= (count_d != CW'(DEPTH));
        end
    end
endmodule
`default_nettype wire

// ===== output_channel_packet_mux.sv
// channel FIFOs, package framer, parameter storage and AXI4-Lite registers
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "output_channel_regs.svh"
module output_channel_packet_mux #(
    parameter int NCH = 2,
    parameter int WORD_BITS = 16,
    parameter int FIFO_DEPTH = `OCM_FIFO_DEPTH,
    parameter bit HAS_SCALAR = 1'b1,
    parameter int SCALAR_BITS = 16,
    parameter int SCALAR_INT_BITS = 3,
    parameter bit SCALAR_SIGNED = 1'b0,
    parameter logic [31:0] SCALAR_INIT = 32'h0000_0000,
    parameter bit HAS_TABLE = 1'b1,
    parameter int TABLE_BITS = 16,
    parameter int TABLE_INT_BITS = 2,
    parameter bit TABLE_SIGNED = 1'b1,
    parameter int TABLE_DEPTH = 32,
    parameter logic [TABLE_DEPTH*TABLE_BITS-1:0] TABLE_INIT = '0,
    parameter bit CHANNEL_SIGNED = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NCH*WORD_BITS-1:0] channel_sample_word,
    input wire logic [NCH-1:0] channel_sample_valid,
    output logic [NCH-1:0] channel_accept,
    output logic [`OCM_STREAM_BITS-1:0] m_axis_tdata,
    output logic m_axis_tvalid,
    output logic m_axis_tlast,
    input wire logic m_axis_tready,
    output logic [SCALAR_BITS-1:0] scalar_param_value,
    input wire logic [$clog2(TABLE_DEPTH)-1:0] table_index,
    input wire logic table_read_strobe,
    output logic [TABLE_BITS-1:0] table_read_word
);
    localparam int SWB = `OCM_SWITCH_BITS;
    localparam int PAY_BITS = `OCM_PAYLOAD_BEATS * `OCM_STREAM_BITS;
    localparam int HDR_CHUNKS = `OCM_HEADER_BEATS * `OCM_STREAM_BITS / SWB;
    localparam int LAST_CHUNK = (`OCM_HEADER_BEATS + `OCM_PAYLOAD_BEATS)
        * `OCM_STREAM_BITS / SWB - 1;
    localparam int ACC_BITS = SWB + WORD_BITS;
    localparam int ACW = $clog2(ACC_BITS + 1);
    localparam int PBW = $clog2(PAY_BITS + 1) + 1;
    localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;
    localparam int TIW = $clog2(TABLE_DEPTH);

    if (NCH < 1 || NCH > `OCM_MAX_CHANNELS) begin : g_chk_nch
        $error("NCH must be 1 to 16");
    end
    if (WORD_BITS < 1 || WORD_BITS > `OCM_MAX_WORD_BITS) begin : g_chk_w
        $error("WORD_BITS must be 1 to 1024");
    end
    if (SCALAR_BITS < 1 || SCALAR_BITS > 32 || TABLE_BITS < 1
        || TABLE_BITS > 32 || TABLE_DEPTH < 2) begin : g_chk_par
        $error("parameter storage widths must be 1 to 32, depth 2 or more");
    end

    // ---------------- register file ----------------
    logic [31:0] ctrl_q;
    logic [31:0] pkg_count_q;
    logic [SCALAR_BITS-1:0] scalar_q;
    logic [TIW-1:0] tab_ptr_q;
    logic [TABLE_BITS-1:0] table_q [TABLE_DEPTH];
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic busy;
    logic [NCH-1:0] fifo_valid;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // both halves of a write are held until the response is accepted
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `OCM_RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                case (awaddr_q)
                    `OCM_OFS_CTRL, `OCM_OFS_SCALAR, `OCM_OFS_TABLE_INDEX,
                    `OCM_OFS_TABLE_DATA: s_axi_bresp <= `OCM_RESP_OKAY;
                    default: s_axi_bresp <= `OCM_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `OCM_CTRL_RESET;
            scalar_q <= SCALAR_INIT[SCALAR_BITS-1:0];
            tab_ptr_q <= '0;
        end else if (ce && wr_fire) begin
            case (awaddr_q)
                `OCM_OFS_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q)
                    & 32'h0000_0003;
                `OCM_OFS_SCALAR: begin
                    if (HAS_SCALAR) begin
                        // upper bits dropped: wrap on overflow
                        scalar_q <= SCALAR_BITS'(merge(32'(scalar_q),
                            wdata_q, wstrb_q));
                    end
                end
                `OCM_OFS_TABLE_INDEX: tab_ptr_q <= wdata_q[TIW-1:0];
                default: begin
                end
            endcase
        end
    end

    // table entries start from the configured vector, one per index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < TABLE_DEPTH; i++) begin
                table_q[i] <= TABLE_INIT[i*TABLE_BITS +: TABLE_BITS];
            end
        end else if (ce && HAS_TABLE && wr_fire
                     && awaddr_q == `OCM_OFS_TABLE_DATA) begin
            table_q[tab_ptr_q] <= TABLE_BITS'(merge(32'(table_q[tab_ptr_q]),
                wdata_q, wstrb_q));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `OCM_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `OCM_RESP_OKAY;
                case (s_axi_araddr)
                    `OCM_OFS_CTRL: s_axi_rdata <= ctrl_q;
                    `OCM_OFS_STATUS: s_axi_rdata <= 32'(fifo_valid)
                        | (32'(busy) << `OCM_STATUS_BUSY_BIT);
                    `OCM_OFS_PKG_COUNT: s_axi_rdata <= pkg_count_q;
                    `OCM_OFS_SCALAR: s_axi_rdata <= 32'(scalar_q);
                    `OCM_OFS_TABLE_INDEX: s_axi_rdata <= 32'(tab_ptr_q);
                    `OCM_OFS_TABLE_DATA: s_axi_rdata <= 32'(table_q[tab_ptr_q]);
                    // sign codes: 0 unsigned, 1 two's complement
                    `OCM_OFS_FORMAT: s_axi_rdata <= {5'h00, CHANNEL_SIGNED,
                        TABLE_SIGNED, SCALAR_SIGNED, 8'(SCALAR_INT_BITS),
                        8'(TABLE_INT_BITS), 8'(WORD_BITS)};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= `OCM_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // parameters held constant toward the user design
    assign scalar_param_value = scalar_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            table_read_word <= '0;
        end else if (ce && HAS_TABLE && table_read_strobe) begin
            table_read_word <= table_q[table_index];
        end
    end

    // ---------------- channel FIFOs ----------------
    logic [NCH-1:0] fifo_ready;
    logic [NCH-1:0] fifo_pop;
    logic [WORD_BITS-1:0] fifo_data [NCH];
    logic shared;

    assign shared = ctrl_q[`OCM_CTRL_SHARED_BIT];
    assign channel_accept = fifo_ready;

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic wr_valid;
        // shared rate: channel 0 valid stands for all; each FIFO takes it
        // while it has room, else one full FIFO starves the open package
        assign wr_valid = shared ? channel_sample_valid[0]
            : channel_sample_valid[i];
        channel_fifo #(
            .WIDTH(WORD_BITS),
            .DEPTH(FIFO_DEPTH)
        ) u_fifo (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .in_data(channel_sample_word[i*WORD_BITS +: WORD_BITS]),
            .in_valid(wr_valid),
            .in_ready(fifo_ready[i]),
            .out_data(fifo_data[i]),
            .out_valid(fifo_valid[i]),
            .out_ready(fifo_pop[i])
        );
    end

    // ---------------- package switch and framer ----------------
    output_channel_pkg::switch_state_t state_q;
    logic [CHW-1:0] grant_q;
    logic [7:0] chunk_q;
    logic [ACC_BITS-1:0] acc_q;
    logic [ACW-1:0] acc_n_q;
    logic [PBW-1:0] pkg_bits_q;
    logic [SWB-1:0] lo_q;
    logic [15:0] seq_q;
    logic in_pkg;
    logic in_hdr;
    logic acc_full;
    logic pad;
    logic slot_ok;
    logic emit;
    logic load;
    logic [SWB-1:0] chunk_word;
    logic [CHW-1:0] next_ch;
    logic next_found;

    assign in_pkg = (state_q == output_channel_pkg::SW_PACKAGE);
    assign busy = in_pkg;
    assign in_hdr = (chunk_q < 8'(HDR_CHUNKS));
    assign acc_full = (acc_n_q >= ACW'(SWB));
    // a sample that would cross the payload end is left for the next package
    assign pad = (pkg_bits_q + PBW'(WORD_BITS) > PBW'(PAY_BITS));
    // odd chunks complete a beat and need the output register free
    assign slot_ok = !chunk_q[0] || !m_axis_tvalid || m_axis_tready;
    assign emit = in_pkg && slot_ok && (in_hdr || acc_full || pad);
    // the granted channel is drained until its package ends
    assign load = in_pkg && !in_hdr && !acc_full && !pad
        && fifo_valid[grant_q];

    for (genvar i = 0; i < NCH; i++) begin : g_pop
        assign fifo_pop[i] = load && (grant_q == CHW'(i));
    end

    always_comb begin
        chunk_word = acc_q[SWB-1:0];
        if (in_hdr) begin
            chunk_word = '0;
            if (chunk_q == 8'h00) begin
                chunk_word[15:0] = 16'(grant_q);
                chunk_word[31:16] = seq_q;
                chunk_word[47:32] = 16'(WORD_BITS);
                chunk_word[63:48] = 16'(NCH);
            end
        end
    end

    always_comb begin
        int idx;
        idx = 0;
        next_ch = grant_q;
        next_found = 1'b0;
        for (int k = 1; k <= NCH; k++) begin
            idx = int'(grant_q) + k;
            if (idx >= NCH) begin
                idx = idx - NCH;
            end
            if (!next_found && fifo_valid[idx]) begin
                next_found = 1'b1;
                next_ch = CHW'(idx);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= output_channel_pkg::SW_IDLE;
            grant_q <= CHW'(NCH - 1);
            chunk_q <= '0;
            seq_q <= '0;
            pkg_count_q <= '0;
        end else if (ce) begin
            case (state_q)
                output_channel_pkg::SW_IDLE: begin
                    chunk_q <= '0;
                    if (ctrl_q[`OCM_CTRL_ENABLE_BIT] && next_found) begin
                        grant_q <= next_ch;
                        state_q <= output_channel_pkg::SW_PACKAGE;
                    end
                end
                output_channel_pkg::SW_PACKAGE: begin
                    if (emit) begin
                        chunk_q <= chunk_q + 8'h01;
                        if (chunk_q == 8'(LAST_CHUNK)) begin
                            state_q <= output_channel_pkg::SW_IDLE;
                            seq_q <= seq_q + 16'h0001;
                            pkg_count_q <= pkg_count_q + 32'h0000_0001;
                        end
                    end
                end
                default: state_q <= output_channel_pkg::SW_IDLE;
            endcase
        end
    end

    // dense packing: each sample lands right above the previous one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q <= '0;
            acc_n_q <= '0;
            pkg_bits_q <= '0;
        end else if (ce) begin
            if (!in_pkg) begin
                acc_q <= '0;
                acc_n_q <= '0;
                pkg_bits_q <= '0;
            end else if (emit && !in_hdr) begin
                acc_q <= acc_q >> SWB;
                acc_n_q <= acc_full ? acc_n_q - ACW'(SWB) : '0;
            end else if (load) begin
                acc_q <= acc_q | (ACC_BITS'(fifo_data[grant_q]) << acc_n_q);
                acc_n_q <= acc_n_q + ACW'(WORD_BITS);
                pkg_bits_q <= pkg_bits_q + PBW'(WORD_BITS);
            end
        end
    end

    // two 128-bit switch words make one 256-bit stream beat
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lo_q <= '0;
            m_axis_tdata <= '0;
            m_axis_tvalid <= 1'b0;
            m_axis_tlast <= 1'b0;
        end else if (ce) begin
            if (m_axis_tvalid && m_axis_tready) begin
                m_axis_tvalid <= 1'b0;
            end
            if (emit && !chunk_q[0]) begin
                lo_q <= chunk_word;
            end else if (emit) begin
                m_axis_tdata <= {chunk_word, lo_q};
                m_axis_tvalid <= 1'b1;
                m_axis_tlast <= (chunk_q == 8'(LAST_CHUNK));
            end
        end
    end
endmodule
`default_nettype wire

// ===== output_channel_packet_mux_sva.sv
// port assertions for the packet mux
`timescale 1ns/10ps
`default_nettype none
module output_channel_packet_mux_sva #(parameter int NCH = 2) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NCH-1:0] channel_sample_valid,
    input wire logic [NCH-1:0] channel_accept,
    input wire logic [255:0] m_axis_tdata,
    input wire logic m_axis_tvalid,
    input wire logic m_axis_tlast,
    input wire logic m_axis_tready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    logic [6:0] beat_q;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence beat_s; m_axis_tvalid && m_axis_tready; endsequence
    sequence stall_s; m_axis_tvalid && !m_axis_tready; endsequence
    // restart on tlast so an early tlast is caught by last_beat_a
    always_ff @(posedge aclk) begin
        if (!aresetn || (m_axis_tvalid && m_axis_tready && m_axis_tlast)) begin
            beat_q <= 7'h00;
        end else if (m_axis_tvalid && m_axis_tready) begin
            beat_q <= beat_q + 7'h01;
        end
    end
    stall_hold_a: assert property (stall_s |=> m_axis_tvalid &&
        $stable(m_axis_tdata) && $stable(m_axis_tlast)) else $error("beat moved");
    header_chan_a: assert property (m_axis_tvalid && beat_q == 7'h00 |->
        m_axis_tdata[15:0] < 16'(NCH) && m_axis_tdata[255:64] == '0)
        else $error("bad header beat");
    second_zero_a: assert property (m_axis_tvalid && beat_q == 7'h01 |->
        m_axis_tdata == '0) else $error("second header beat not zero");
    last_beat_a: assert property (beat_s |->
        m_axis_tlast == (beat_q == 7'h41)) else $error("tlast misplaced");
    fill_zero_a: assert property ($fell(channel_accept[0]) |->
        $past(channel_sample_valid[0])) else $error("accept 0 fell idle");
    // shared rate lets channel 0 valid fill channel 1 as well
    fill_one_a: assert property ($fell(channel_accept[1]) |->
        $past(channel_sample_valid[1] || channel_sample_valid[0]))
        else $error("accept 1 fell idle");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready during response");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
endmodule
bind output_channel_packet_mux output_channel_packet_mux_sva #(.NCH(NCH))
    sva_i (.*);
`default_nettype wire

// ===== user_sample_source.sv
// user logic model: per-channel sample sources
`timescale 1ns/10ps
`default_nettype none
module user_sample_source #(parameter int NCH = 2, parameter int W = 100) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NCH-1:0] go,
    input wire logic [NCH-1:0] channel_accept,
    output logic [NCH*W-1:0] channel_sample_word,
    output logic [NCH-1:0] channel_sample_valid
);
    logic [15:0] seq_q [NCH];
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NCH; i++) begin
            if (!aresetn) begin
                channel_sample_valid[i] <= 1'b0;
                channel_sample_word[i*W +: W] <= '0;
                seq_q[i] <= 16'h0000;
            end else if (!channel_sample_valid[i] || channel_accept[i]) begin
                channel_sample_valid[i] <= go[i];
                seq_q[i] <= seq_q[i] + 16'(go[i]);
                // idle word inverted so a stale sample never looks fresh
                channel_sample_word[i*W +: W] <= go[i] ?
                    W'({7{seq_q[i] ^ 16'(i * 4369)}}) :
                    ~channel_sample_word[i*W +: W];
            end
        end
    end
endmodule
`default_nettype wire

// ===== output_channel_packet_mux_tb_top.sv
// self-checking bench for the packet mux
`timescale 1ns/10ps
`default_nettype none
module output_channel_packet_mux_tb_top;
    localparam int W = 100;
    localparam int NS = 16384 / W;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, tready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d, rs = 80;
    logic [1:0] bresp, rresp, r, go = 0;
    logic awready, wready, bvalid, arready, rvalid, tvalid, tlast;
    logic [2*W-1:0] word;
    logic [1:0] valid, accept;
    logic [255:0] tdata;
    logic [15:0] scal, tword;
    logic [W-1:0] q [2][$];
    logic [16383:0] pl;
    int num_errors = 0, num_checks = 0, bt = 0, pk = 0, kf = 0;
    int p0 = 0;
    logic run = 1, sh = 0, tstb = 0;
    logic [4:0] tix = 0;
    logic [3:0] ws = 4'hF;
    output_channel_packet_mux #(.NCH(2), .WORD_BITS(W)) dut (.aclk(aclk),
        .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .channel_sample_word(word),
        .channel_sample_valid(valid), .channel_accept(accept),
        .m_axis_tdata(tdata), .m_axis_tvalid(tvalid), .m_axis_tlast(tlast),
        .m_axis_tready(tready), .scalar_param_value(scal),
        .table_index(tix), .table_read_strobe(tstb),
        .table_read_word(tword));
    user_sample_source #(.NCH(2), .W(W)) src (.aclk(aclk),
        .aresetn(aresetn), .go(go), .channel_accept(accept),
        .channel_sample_word(word), .channel_sample_valid(valid));
    always #5 aclk = ~aclk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // channel 0 always offers, so it wins the first grant
    always @(posedge aclk) begin
        rs = xs(rs);
        tready <= rs[0] | rs[1];
        go <= {aresetn & run & (rs[2] | rs[3]), aresetn & run};
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            bt = 0;
            p0 = pk;
            q[0].delete();
            q[1].delete();
        end
        for (int i = 0; i < 2; i++)
            if (aresetn && (sh ? valid[0] : valid[i]) && accept[i])
                q[i].push_back(word[i*W +: W]);
        if (aresetn && tvalid && tready) begin
            if (bt == 0) begin
                pl = '0;
                kf = 0;
                chk(tdata, {192'h0, 16'h0002, 16'(W), 16'(pk - p0),
                    16'((pk - p0) % 2)});
            end else if (bt == 1) begin
                chk(tdata, '0);
            end else begin
                while (kf < NS && kf * W < (bt - 1) * 256) begin
                    pl[kf*W +: W] = q[(pk - p0) % 2].pop_front();
                    kf++;
                end
                chk(tdata, pl[(bt-2)*256 +: 256]);
            end
            chk(256'(tlast), 256'(bt == 65));
            pk = (bt == 65) ? pk + 1 : pk;
            bt = (bt == 65) ? 0 : bt + 1;
        end
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h18);
        chk(256'(d), 256'(32'h0203_0264));
        wr(8'h0C, 32'h0001_2345);
        chk(256'(r), 256'(2'h0));
        chk(256'(scal), 256'(16'h2345));
        rd(8'h0C);
        chk(256'(d), 256'(32'h0000_2345));
        wr(8'h04, 32'hFFFF_FFFF);
        chk(256'(r), 256'(2'h2));
        wr(8'h40, 32'h0000_0001);
        chk(256'(r), 256'(2'h2));
        rd(8'h40);
        chk(256'({r, d}), 256'({2'h2, 32'h0}));
        ws <= 4'h2;
        wr(8'h0C, 32'h0000_AB00);
        chk(256'(scal), 256'(16'hAB45));
        ws <= 4'hF;
        wr(8'h10, 32'h0000_0003);
        wr(8'h14, 32'h0001_8765);
        rd(8'h14);
        chk(256'(d), 256'(32'h0000_8765));
        tix <= 5'h03;
        tstb <= 1'b1;
        @(posedge aclk);
        tstb <= 1'b0;
        @(posedge aclk);
        chk(256'(tword), 256'(16'h8765));
        wait (pk == 4);
        // second reset mid-stream, then the same traffic at a shared rate
        @(posedge aclk);
        run <= 1'b0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        wr(8'h00, 32'h0000_0003);
        sh = 1'b1;
        run <= 1'b1;
        rd(8'h00);
        chk(256'(d), 256'(32'h0000_0003));
        wait (pk == 6);
        close_out;
    end
    initial begin
        #300000;
        num_errors++;
        close_out;
    end
endmodule
`default_nettype wire
